// >>> design/crcg_pkg.sv
package crcg_pkg;
  localparam logic [1:0] CRCG_POLY_CCITT = 2'h0;
  localparam logic [1:0] CRCG_POLY_CRC16 = 2'h1;
  localparam logic [1:0] CRCG_POLY_CRC32 = 2'h2;
  localparam logic [31:0] CRCG_GEN_CCITT = 32'h00001021;
  localparam logic [31:0] CRCG_GEN_CRC16 = 32'h00008005;
  localparam logic [31:0] CRCG_GEN_CRC32 = 32'h04c11db7;
  localparam logic [31:0] CRCG_SEED_RST = 32'h00000000;
  localparam logic [1:0] CRCG_SIZE_BYTE = 2'h0;
  localparam logic [1:0] CRCG_SIZE_HALF = 2'h1;
  localparam logic [1:0] CRCG_SIZE_WORD = 2'h2;
  localparam logic [2:0] CRCG_STEPS_BYTE = 3'h1;
  localparam logic [2:0] CRCG_STEPS_HALF = 3'h2;
  localparam logic [2:0] CRCG_STEPS_WORD = 3'h4;

  typedef enum logic [0:0] {
    CRCG_IDLE = 1'b0,
    CRCG_BUSY = 1'b1
  } crcg_state_e_t;

  typedef struct packed {
    logic [1:0] poly;
    logic rev_in;
    logic inv_in;
    logic rev_out;
    logic inv_out;
  } crcg_mode_t;

  typedef struct packed {
    logic [31:0] data;
    logic [1:0] size;
  } crcg_wr_t;

  typedef struct packed {
    crcg_state_e_t state;
    logic [31:0] sum;
    logic [31:0] data;
    logic [2:0] left;
    logic [31:0] result;
  } crcg_state_t;
endpackage

// >>> design/crcg_byte_step.sv
`timescale 1ns/1ps
module crcg_byte_step
  import crcg_pkg::*;
(
  // running sum and byte
  input wire logic [31:0] sum_in,
  input wire logic [7:0] byte_in,
  input wire logic [1:0] poly,
  // next sum
  output logic [31:0] sum_out
);
  logic [31:0] gen;
  logic wide;
  logic fb;
  logic [31:0] s;

  always_comb begin
    wide = (poly == CRCG_POLY_CRC32);
    if (poly == CRCG_POLY_CRC16) begin
      gen = CRCG_GEN_CRC16;
    end else if (wide) begin
      gen = CRCG_GEN_CRC32;
    end else begin
      gen = CRCG_GEN_CCITT;
    end
    s = sum_in;
    fb = 1'b0;
    // msb-first division, eight bits per call
    for (int i = 7; i >= 0; i--) begin
      fb = byte_in[i] ^ (wide ? s[31] : s[15]);
      s = {s[30:0], 1'b0} ^ (fb ? gen : 32'h00000000);
    end
    sum_out = wide ? s : {16'h0000, s[15:0]};
  end
endmodule

// >>> design/crcg_engine.sv
`timescale 1ns/1ps
module crcg_engine
  import crcg_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // configuration
  input wire crcg_mode_t mode,
  // seed load
  input wire logic seed_wr,
  input wire logic [31:0] seed,
  // data write channel
  input wire logic wr_valid,
  input wire crcg_wr_t wr,
  output logic wr_ready,
  // result
  output logic [31:0] result,
  output logic busy
);
  crcg_state_t q;
  crcg_state_t next_q;
  logic [31:0] in_word;
  logic [31:0] step_sum;
  logic [7:0] step_byte;
  logic [2:0] steps;
  logic [31:0] mask;
  logic [31:0] rev_sum;
  logic take;

  function automatic logic [31:0] crcg_mirror(input logic [31:0] v, input logic [1:0] p);
    logic [31:0] r;
    r = 32'h00000000;
    for (int i = 0; i < 32; i++) begin
      r[31 - i] = v[i];
    end
    if (p != CRCG_POLY_CRC32) begin
      r = {16'h0000, r[31:16]};
    end
    return r;
  endfunction

  function automatic logic [31:0] crcg_in_prep(input logic [31:0] v, input crcg_mode_t m);
    logic [31:0] r;
    r = v;
    if (m.rev_in) begin
      // mirror inside each byte, so lane order stays low byte first
      for (int b = 0; b < 4; b++) begin
        for (int i = 0; i < 8; i++) begin
          r[8 * b + i] = v[8 * b + 7 - i];
        end
      end
    end
    if (m.inv_in) begin
      r = ~r;
    end
    return r;
  endfunction

  crcg_byte_step u_step (
    .sum_in(q.sum),
    .byte_in(step_byte),
    .poly(mode.poly),
    .sum_out(step_sum)
  );

  always_comb begin
    // new write only when idle; stall holds the bus
    wr_ready = (q.state == CRCG_IDLE) && !seed_wr;
    take = wr_valid && wr_ready;
    in_word = crcg_in_prep(wr.data, mode);
    case (wr.size)
      CRCG_SIZE_HALF: steps = CRCG_STEPS_HALF;
      CRCG_SIZE_WORD: steps = CRCG_STEPS_WORD;
      default: steps = CRCG_STEPS_BYTE;
    endcase
    step_byte = q.data[7:0];
    mask = (mode.poly == CRCG_POLY_CRC32) ? 32'hffffffff : 32'h0000ffff;
    rev_sum = mode.rev_out ? crcg_mirror(q.sum, mode.poly) : q.sum;
    next_q = q;
    next_q.result = (mode.inv_out ? ~rev_sum : rev_sum) & mask;
    case (q.state)
      CRCG_IDLE: begin
        if (take) begin
          // first byte folded in the accept cycle is not possible: sum reads q.data
          next_q.data = in_word;
          next_q.left = steps;
          next_q.state = CRCG_BUSY;
        end
      end
      CRCG_BUSY: begin
        next_q.sum = step_sum & mask;
        next_q.data = {8'h00, q.data[31:8]};
        next_q.left = q.left - 3'h1;
        if (q.left == 3'h1) begin
          next_q.state = CRCG_IDLE;
        end
      end
      default: next_q.state = CRCG_IDLE;
    endcase
    if (seed_wr) begin
      // seed wins and aborts any write in flight
      next_q.sum = seed & mask;
      next_q.state = CRCG_IDLE;
      next_q.left = 3'h0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      q <= '{state: CRCG_IDLE, sum: CRCG_SEED_RST, data: 32'h00000000,
             left: 3'h0, result: 32'h00000000};
    end else begin
      q <= next_q;
    end
  end

  assign result = q.result;
  assign busy = (q.state == CRCG_BUSY);

  a_byte_one_cycle: assert property (@(posedge sys_clk) disable iff (reset)
    (take && wr.size == CRCG_SIZE_BYTE && !seed_wr) |=> busy ##1 !busy)
    else $error("byte write not one step");
  a_half_two_cycle: assert property (@(posedge sys_clk) disable iff (reset)
    (take && wr.size == CRCG_SIZE_HALF && !seed_wr) |=> (busy && !seed_wr) [*2] ##1 !busy)
    else $error("halfword write not two steps");
  a_word_four_cycle: assert property (@(posedge sys_clk) disable iff (reset)
    (take && wr.size == CRCG_SIZE_WORD) ##1 (!seed_wr) [*4] |=> !busy)
    else $error("word write not four steps");
  a_stall_while_busy: assert property (@(posedge sys_clk) disable iff (reset)
    busy |-> !wr_ready)
    else $error("write accepted during steps");
  a_seed_loads: assert property (@(posedge sys_clk) disable iff (reset)
    seed_wr |=> (q.sum == ($past(seed) & $past(mask))) && !busy)
    else $error("seed not loaded");
  a_idle_ready: assert property (@(posedge sys_clk) disable iff (reset)
    (!busy && !seed_wr) |-> wr_ready)
    else $error("idle engine refused write");
  a_sum_width: assert property (@(posedge sys_clk) disable iff (reset)
    (mode.poly != CRCG_POLY_CRC32 && $stable(mode.poly)) |=> q.sum[31:16] == 16'h0000
      || $past(mode.poly) == CRCG_POLY_CRC32)
    else $error("16-bit sum overflowed");
  a_low_byte_first: assert property (@(posedge sys_clk) disable iff (reset)
    (take && !seed_wr) |=> step_byte == $past(in_word[7:0]))
    else $error("first step not low byte");
  a_result_inv: assert property (@(posedge sys_clk) disable iff (reset)
    (mode.inv_out && !mode.rev_out && $stable(mode)) |=> result == (~$past(q.sum) & $past(mask)))
    else $error("result inversion wrong");

  c_byte: cover property (@(posedge sys_clk) take && wr.size == CRCG_SIZE_BYTE);
  c_word: cover property (@(posedge sys_clk) take && wr.size == CRCG_SIZE_WORD);
  c_back_to_back: cover property (@(posedge sys_clk) take ##2 take);
  c_seed_abort: cover property (@(posedge sys_clk) busy && seed_wr);
endmodule

// >>> bench/crcg_writer.sv
`timescale 1ns/1ps
module crcg_writer
  import crcg_pkg::*;
(
  // bus side
  input wire logic sys_clk,
  input wire logic wr_ready,
  output logic wr_valid,
  output crcg_wr_t wr,
  output logic stuck
);
  initial begin
    wr_valid = 1'b0;
    wr = '0;
    stuck = 1'b0;
  end
  // request held until ready is seen at an edge, released lines scrambled
  task automatic put(input logic [31:0] d, input logic [1:0] s, input bit we, input bit dr);
    int i;
    logic rdy;
    if (we) @(posedge sys_clk);
    wr_valid <= 1'b1;
    wr <= {d, s};
    // ready is combinational off state: sample it mid-cycle, not at the racing edge
    for (i = 0; i < 20; i++) begin
      @(negedge sys_clk);
      rdy = wr_ready;
      @(posedge sys_clk);
      if (rdy === 1'b1) break;
    end
    if (i == 20) stuck <= 1'b1;
    if (dr) begin
      wr_valid <= 1'b0;
      wr <= ~{d, s};
    end
  endtask
endmodule

// >>> bench/tb_crcg_engine.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_crcg_engine
  import crcg_pkg::*;
;
  logic sys_clk = 0, reset = 1, seed_wr = 0, wr_ready, busy, wr_valid, stuck;
  logic [31:0] seed = '0, result, sum;
  crcg_mode_t mode = '0;
  crcg_wr_t wr;
  int num_errors = 0, samples_checked = 0;
  crcg_engine dut (.sys_clk, .reset, .mode, .seed_wr, .seed, .wr_valid, .wr, .wr_ready,
    .result, .busy);
  crcg_writer w (.sys_clk, .wr_ready, .wr_valid, .wr, .stuck);
  initial forever #4 sys_clk = ~sys_clk;
  // bitwise reference, msb of each byte first
  task automatic feed(input logic [31:0] d, input int n);
    logic [7:0] b;
    logic [31:0] g;
    int t;
    t = mode.poly == CRCG_POLY_CRC32 ? 31 : 15;
    g = mode.poly == CRCG_POLY_CRC32 ? CRCG_GEN_CRC32 :
      mode.poly == CRCG_POLY_CRC16 ? CRCG_GEN_CRC16 : CRCG_GEN_CCITT;
    for (int i = 0; i < n; i++) begin
      b = mode.inv_in ? ~d[8*i+:8] : d[8*i+:8];
      if (mode.rev_in) b = {<<{b}};
      for (int k = 7; k >= 0; k--) sum = (sum << 1) ^ ((sum[t] ^ b[k]) ? g : 32'h0);
    end
    if (t == 15) sum[31:16] = 16'h0;
  endtask
  function automatic logic [31:0] exp_out();
    logic [31:0] r;
    r = mode.rev_out ? {<<{sum}} : sum;
    if (mode.rev_out && mode.poly != CRCG_POLY_CRC32) r = r >> 16;
    if (mode.inv_out) r = ~r;
    return mode.poly == CRCG_POLY_CRC32 ? r : {16'h0, r[15:0]};
  endfunction
  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic set_seed(input crcg_mode_t m, input logic [31:0] v);
    @(posedge sys_clk);
    mode <= m;
    seed_wr <= 1'b1;
    seed <= v;
    @(posedge sys_clk);
    seed_wr <= 1'b0;
    seed <= ~v;
    sum = m.poly == CRCG_POLY_CRC32 ? v : {16'h0, v[15:0]};
    @(posedge sys_clk);
    #1;
    `CHK("seed result", exp_out(), result)
  endtask
  task automatic done(input int n);
    int c;
    // called at the accept edge: busy counted from the cycle right after it
    #1;
    for (c = 0; c < 20; c++) begin
      if (busy !== 1'b1) break;
      @(posedge sys_clk);
      #1;
    end
    `CHK("busy cycles", n, c)
    if (c == 20) conclude();
    @(posedge sys_clk);
    #1;
    `CHK("result", exp_out(), result)
  endtask
  task automatic t_polys();
    for (int p = 0; p < 3; p++) begin
      set_seed({2'(p), 4'h0}, 32'hffffffff);
      w.put(32'h12345678, CRCG_SIZE_WORD, 1, 1);
      feed(32'h12345678, 4);
      done(4);
    end
  endtask
  // every flag mix but all-zero, byte and halfword alternating
  task automatic t_flags();
    for (int f = 1; f < 16; f++) begin
      set_seed({2'(f % 3), 4'(f)}, 32'h5a5a1234);
      w.put(32'hc3a1beef, f[0] ? CRCG_SIZE_HALF : CRCG_SIZE_BYTE, 1, 1);
      feed(32'hc3a1beef, f[0] ? 2 : 1);
      done(f[0] ? 2 : 1);
    end
  endtask
  // second write queued behind the first, no idle gap
  task automatic t_b2b();
    set_seed(6'h0, 32'h0);
    w.put(32'hffffffa5, CRCG_SIZE_BYTE, 1, 0);
    w.put(32'h00001234, CRCG_SIZE_HALF, 0, 1);
    feed(32'hffffffa5, 1);
    feed(32'h00001234, 2);
    done(2);
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    t_polys();
    t_flags();
    t_b2b();
    `CHK("writer stall", 1'b0, stuck)
    conclude();
  end
endmodule
